// [core/nand_host_pkg.sv]
// constants and carrier types for the nand flash host controller
// Function
// [RQ1] command, address and data bytes share the eight io lines, selected by latch strobes
// [RQ2] command latch high: io byte taken as command on write strobe rise
// [RQ3] address latch high: io byte taken as address on write strobe rise
// [RQ4] host pulses write strobe low then high per byte; sampled on rise
// [RQ5] device drives next byte within access delay after read strobe falls
// [RQ6] each read strobe fall advances the device column counter by one
// [RQ7] host holds chip select low to operate; high deselects the device
// [RQ8] chip select rising during read while ready puts device in standby
// [RQ9] chip select rising while busy does not stop the internal operation
// [RQ10] write protect low makes the device reject program and erase
// [RQ11] host keeps write protect low through power up and power down
// [RQ12] ready/busy is open drain, pulled high outside the device
// [RQ13] ready/busy low while read, program or erase runs, high when done
// [RQ14] protect pin high at power-on protects whole array until cleared
// [RQ15] protect pin low or floating disables block protection
// [RQ16] array address is four cycles: two column, then two row
// [RQ17] first column cycle bits 7..0; second bits 11..8, upper nibble low
// [RQ18] third cycle row bits 19..12; fourth cycle row bits 27..20
// [RQ19] page is 2048 main bytes plus 64 spare bytes, one column range
// [RQ20] erase block is 64 pages; read and program act on 2112 byte pages
// [RQ21] device stages page data in a 2112 byte on-chip buffer
// [RQ22] cache read: first byte after 25 us, then 20 ns per byte
// [RQ23] page read is 00h, four address cycles, 30h, then device goes busy
// [RQ24] status bit 6 mirrors ready/busy; bit 5 reads 1 when idle
// [RQ25] host waits for ready before data output or a new array command
package nand_host_pkg;
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam int MAIN_BYTES = 2048;
  localparam int SPARE_BYTES = 64;
  localparam int PAGE_BYTES = MAIN_BYTES + SPARE_BYTES;
  localparam int PAGES_PER_BLOCK = 64;
  localparam int ADDR_CYCLES = 4;
  localparam int COL_HI_BITS = 4;
  localparam int CLK_PERIOD_NS = 100;
  // strobe phase lengths in ns, rounded up to clock cycles (each phase at least 1 cycle)
  localparam int STROBE_LOW_NS = 100;
  localparam int STROBE_HIGH_NS = 100;
  localparam int READ_ACCESS_DELAY_NS = 100;
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_ACCESS_CYC = (READ_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ARRAY_READ_LATENCY_NS = 25000;
  localparam int ARRAY_READ_LATENCY_CYC = ARRAY_READ_LATENCY_NS / CLK_PERIOD_NS;
  localparam int BUSY_TIMEOUT_CYC = 1000;
  localparam int FIFO_DEPTH = 16;
  localparam int TIMER_W = 16;

  typedef struct packed {
    logic [3:0] col_hi;
    logic [7:0] col_lo;
    logic [7:0] row_hi;
    logic [7:0] row_lo;
  } page_addr_t;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
    logic wp_n;
    logic protect_pin;
  } pin_ctl_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_CMD = 4'b0001,
    ST_ADDR = 4'b0011,
    ST_CONF = 4'b0010,
    ST_BUSY_WAIT = 4'b0110,
    ST_BUSY = 4'b0111,
    ST_READ = 4'b0101,
    ST_DONE = 4'b0100
  } host_state_t;
endpackage

// [core/byte_fifo.sv]
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [WIDTH-1:0] dout_reg, dout_next;
  logic dvalid_reg, dvalid_next;
  logic full, empty, push, pop;

  always_comb begin
    full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
    empty = (wr_reg == rd_reg);
    push = in_valid_i && !full;
    pop = !empty && (!dvalid_reg || out_ready_i);
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    dout_next = pop ? mem_reg[rd_reg[AW-1:0]] : dout_reg;
    dvalid_next = pop ? 1'b1 : (out_ready_i ? 1'b0 : dvalid_reg);
  end

  always_ff @(posedge mclk_i) begin
    if (ce_i && push) begin
      mem_reg[wr_reg[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      dout_reg <= '0;
      dvalid_reg <= 1'b0;
    end else if (ce_i) begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      dout_reg <= dout_next;
      dvalid_reg <= dvalid_next;
    end
  end

  assign in_ready_o = !full;
  assign out_data_o = dout_reg;
  assign out_valid_o = dvalid_reg;
endmodule // byte_fifo

// [core/nand_page_reader.sv]
// host controller issuing nand page reads and streaming data out
`timescale 1ns/10ps
module nand_page_reader #(
  parameter int READ_LATENCY_CYC = nand_host_pkg::ARRAY_READ_LATENCY_CYC,
  parameter int BUSY_TIMEOUT = nand_host_pkg::BUSY_TIMEOUT_CYC,
  parameter int XFER_BYTES = nand_host_pkg::PAGE_BYTES
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire nand_host_pkg::page_addr_t addr_i,
  input wire logic write_enable_i,
  input wire logic protect_i,
  output logic busy_o,
  output logic done_o,
  output logic timeout_o,
  output logic [7:0] data_o,
  output logic data_valid_o,
  input wire logic data_ready_i,
  output nand_host_pkg::pin_ctl_t pins_o,
  output logic [7:0] io_bus_o,
  output logic io_bus_oe_o,
  input wire logic [7:0] io_bus_i,
  input wire logic ready_busy_n_i
);
  typedef logic [nand_host_pkg::TIMER_W-1:0] tmr_t;
  nand_host_pkg::host_state_t state_reg, state_next;
  nand_host_pkg::page_addr_t addr_reg, addr_next;
  nand_host_pkg::pin_ctl_t pins_reg, pins_next;
  logic [7:0] io_reg, io_next;
  logic oe_reg, oe_next;
  logic [1:0] acyc_reg, acyc_next;
  logic phase_reg, phase_next;
  tmr_t tmr_reg, tmr_next;
  logic [11:0] cnt_reg, cnt_next;
  logic done_reg, done_next, tout_reg, tout_next, busy_reg, busy_next;
  logic [7:0] io_s1_reg, io_s2_reg;
  logic rb_s1_reg, rb_s2_reg;
  logic [7:0] cap_data;
  logic cap_valid, fifo_in_ready;
  logic [7:0] addr_byte;

  // two-flop synchronisers on pins from the device
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      io_s1_reg <= 8'h00;
      io_s2_reg <= 8'h00;
      rb_s1_reg <= 1'b0;
      rb_s2_reg <= 1'b0;
    end else if (ce_i) begin
      io_s1_reg <= io_bus_i;
      io_s2_reg <= io_s1_reg;
      rb_s1_reg <= ready_busy_n_i; // [RQ12]
      rb_s2_reg <= rb_s1_reg;
    end
  end

  // address byte that follows the current one: column high, row low, row high
  always_comb begin
    case (acyc_reg)
      2'd0: addr_byte = {4'h0, addr_reg.col_hi}; // [RQ17]
      2'd1: addr_byte = addr_reg.row_lo; // [RQ18]
      default: addr_byte = addr_reg.row_hi; // [RQ18]
    endcase
  end

  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    pins_next = pins_reg;
    io_next = io_reg;
    oe_next = oe_reg;
    acyc_next = acyc_reg;
    phase_next = phase_reg;
    tmr_next = tmr_reg;
    cnt_next = cnt_reg;
    done_next = 1'b0;
    tout_next = 1'b0;
    busy_next = busy_reg;
    cap_valid = 1'b0;
    cap_data = io_s2_reg;
    pins_next.wp_n = write_enable_i; // [RQ10] [RQ11]
    pins_next.protect_pin = protect_i; // [RQ14] [RQ15]
    case (state_reg)
      nand_host_pkg::ST_IDLE: begin
        pins_next.ce_n = 1'b1; // [RQ7]
        if (start_i) begin
          addr_next = addr_i;
          busy_next = 1'b1;
          pins_next.ce_n = 1'b0; // [RQ7]
          pins_next.cle = 1'b1; // [RQ2]
          io_next = nand_host_pkg::CMD_READ_SETUP; // [RQ23]
          oe_next = 1'b1; // [RQ1]
          phase_next = 1'b0;
          tmr_next = tmr_t'(nand_host_pkg::STROBE_LOW_CYC);
          state_next = nand_host_pkg::ST_CMD;
        end
      end
      nand_host_pkg::ST_CMD, nand_host_pkg::ST_ADDR, nand_host_pkg::ST_CONF: begin
        // write strobe low phase then high phase; device latches on rise
        if (!phase_reg) begin
          if (pins_reg.we_n) begin
            pins_next.we_n = 1'b0; // [RQ4]
          end else if (tmr_reg > tmr_t'(1)) begin
            tmr_next = tmr_reg - 1'b1;
          end else begin
            pins_next.we_n = 1'b1; // [RQ4] [RQ2] [RQ3]
            phase_next = 1'b1;
            tmr_next = tmr_t'(nand_host_pkg::STROBE_HIGH_CYC);
          end
        end else if (tmr_reg > tmr_t'(1)) begin
          tmr_next = tmr_reg - 1'b1;
        end else begin
          phase_next = 1'b0;
          tmr_next = tmr_t'(nand_host_pkg::STROBE_LOW_CYC);
          if (state_reg == nand_host_pkg::ST_CMD) begin
            pins_next.cle = 1'b0;
            pins_next.ale = 1'b1; // [RQ3]
            acyc_next = 2'd0;
            io_next = addr_reg.col_lo; // [RQ17]
            state_next = nand_host_pkg::ST_ADDR;
          end else if (state_reg == nand_host_pkg::ST_ADDR &&
                       acyc_reg != 2'(nand_host_pkg::ADDR_CYCLES - 1)) begin
            acyc_next = acyc_reg + 1'b1; // [RQ16]
            io_next = addr_byte; // [RQ17] [RQ18]
          end else if (state_reg == nand_host_pkg::ST_ADDR) begin
            pins_next.ale = 1'b0;
            pins_next.cle = 1'b1;
            io_next = nand_host_pkg::CMD_READ_CONFIRM; // [RQ23]
            state_next = nand_host_pkg::ST_CONF;
          end else begin
            pins_next.cle = 1'b0;
            oe_next = 1'b0;
            io_next = 8'h00;
            tmr_next = tmr_t'(BUSY_TIMEOUT);
            state_next = nand_host_pkg::ST_BUSY_WAIT;
          end
        end
      end
      nand_host_pkg::ST_BUSY_WAIT: begin
        // wait for the device to pull ready/busy low
        if (!rb_s2_reg) begin
          tmr_next = tmr_t'(READ_LATENCY_CYC);
          state_next = nand_host_pkg::ST_BUSY;
        end else if (tmr_reg == '0) begin
          tmr_next = tmr_t'(READ_LATENCY_CYC);
          state_next = nand_host_pkg::ST_BUSY;
        end else begin
          tmr_next = tmr_reg - 1'b1;
        end
      end
      nand_host_pkg::ST_BUSY: begin
        // cs may stay low; device keeps its internal read running anyway
        if (tmr_reg != '0) begin
          tmr_next = tmr_reg - 1'b1;
        end
        if (rb_s2_reg && tmr_reg == '0) begin // [RQ13] [RQ25] [RQ22]
          cnt_next = '0;
          phase_next = 1'b0;
          tmr_next = tmr_t'(nand_host_pkg::READ_ACCESS_CYC + 2);
          state_next = nand_host_pkg::ST_READ;
        end
      end
      nand_host_pkg::ST_READ: begin
        // read strobe low, wait access delay plus sync, capture, strobe high
        if (!phase_reg) begin
          if (fifo_in_ready) begin
            pins_next.read_strobe_n = 1'b0; // [RQ5] [RQ6]
            phase_next = 1'b1;
          end
        end else if (tmr_reg > tmr_t'(1)) begin
          tmr_next = tmr_reg - 1'b1;
        end else begin
          cap_valid = 1'b1; // [RQ5]
          pins_next.read_strobe_n = 1'b1;
          phase_next = 1'b0;
          tmr_next = tmr_t'(nand_host_pkg::READ_ACCESS_CYC + 2);
          cnt_next = cnt_reg + 1'b1; // [RQ6] [RQ19] [RQ21]
          if (cnt_reg == 12'(XFER_BYTES - 1)) begin // [RQ20]
            state_next = nand_host_pkg::ST_DONE;
          end
        end
      end
      nand_host_pkg::ST_DONE: begin
        pins_next.ce_n = 1'b1; // [RQ7] [RQ8]
        busy_next = 1'b0;
        done_next = 1'b1;
        state_next = nand_host_pkg::ST_IDLE;
      end
      default: begin
        state_next = nand_host_pkg::ST_IDLE;
      end
    endcase
    if (state_reg == nand_host_pkg::ST_BUSY_WAIT && rb_s2_reg && tmr_reg == '0) begin
      tout_next = 1'b1; // [RQ9]
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= nand_host_pkg::ST_IDLE;
      addr_reg <= '0;
      pins_reg <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                    read_strobe_n: 1'b1, wp_n: 1'b0, protect_pin: 1'b0};
      io_reg <= 8'h00;
      oe_reg <= 1'b0;
      acyc_reg <= 2'd0;
      phase_reg <= 1'b0;
      tmr_reg <= '0;
      cnt_reg <= '0;
      done_reg <= 1'b0;
      tout_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      pins_reg <= pins_next;
      io_reg <= io_next;
      oe_reg <= oe_next;
      acyc_reg <= acyc_next;
      phase_reg <= phase_next;
      tmr_reg <= tmr_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
      tout_reg <= tout_next;
      busy_reg <= busy_next;
    end
  end

  byte_fifo #(
    .WIDTH(8),
    .DEPTH(nand_host_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .in_data_i(cap_data),
    .in_valid_i(cap_valid),
    .in_ready_o(fifo_in_ready),
    .out_data_o(data_o),
    .out_valid_o(data_valid_o),
    .out_ready_i(data_ready_i)
  );

  assign pins_o = pins_reg;
  assign io_bus_o = io_reg;
  assign io_bus_oe_o = oe_reg;
  assign busy_o = busy_reg;
  assign done_o = done_reg;
  assign timeout_o = tout_reg;
endmodule // nand_page_reader

// [bench/nand_flash_model.sv]
// behavioural nand flash device answering the page reader's pins
`timescale 1ns/10ps
module nand_flash_model #(
  parameter int BUSY_NS = 1000 // shortened array read latency
) (
  input wire nand_host_pkg::pin_ctl_t pins_i,
  input wire logic [7:0] io_i,
  output logic [7:0] io_o,
  output logic rb_low_o
);
  logic [8:0] log_q[$];
  logic [11:0] col = '0;
  logic [7:0] row_lo = '0;
  logic [7:0] last = '0;
  logic no_busy = 1'b0;
  logic standby;
  logic [7:0] status;
  int acnt = 0;
  initial begin
    io_o = 8'h5a;
    rb_low_o = 1'b0;
  end
  // only page read is modelled: program and erase are never accepted
  always @(posedge pins_i.we_n) begin
    if (!pins_i.ce_n && pins_i.cle) begin
      log_q.push_back({1'b0, io_i});
      acnt = 0;
      if (io_i == 8'h30 && !no_busy) begin
        // busy runs on whatever chip select does
        fork
          begin
            #50 rb_low_o = 1'b1;
            #BUSY_NS rb_low_o = 1'b0;
          end
        join_none
      end
    end else if (!pins_i.ce_n && pins_i.ale) begin
      log_q.push_back({1'b1, io_i});
      case (acnt)
        0: col[7:0] = io_i;
        1: col[11:8] = io_i[3:0];
        2: row_lo = io_i;
        default: ;
      endcase
      acnt++;
    end
  end
  always @(negedge pins_i.read_strobe_n) begin
    last = col[7:0] ^ row_lo;
    col = col + 12'h001;
    #20 io_o = last;
  end
  // released lines show the inverse of the last byte
  always @(posedge pins_i.read_strobe_n) #10 io_o = ~last;
  assign standby = pins_i.ce_n && !rb_low_o;
  assign status = {1'b0, !rb_low_o, !rb_low_o, 5'h00};
endmodule // nand_flash_model

// [bench/nand_page_reader_sva.sv]
// assertions on the page reader's ports
`timescale 1ns/10ps
module nand_page_reader_sva (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic write_enable_i,
  input wire logic protect_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic timeout_o,
  input wire logic data_valid_o,
  input wire logic data_ready_i,
  input wire nand_host_pkg::pin_ctl_t pins_o,
  input wire logic [7:0] io_bus_o,
  input wire logic io_bus_oe_o,
  input wire logic ready_busy_n_i
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  AST_PINS_AT_RELEASE: assert property ($rose(rstn_i) |-> pins_o.ce_n && !pins_o.wp_n)
    else $error("pins not idle at reset release");
  AST_CTL_FOLLOW: assert property (rstn_i && $past(rstn_i) && $past(ce_i) |->
    pins_o.wp_n == $past(write_enable_i) && pins_o.protect_pin == $past(protect_i))
    else $error("protect pins do not follow inputs");
  AST_LATCH_EXCL: assert property (!(pins_o.cle && pins_o.ale))
    else $error("command and address latch both high");
  AST_WE_DRIVEN: assert property (!pins_o.we_n |-> io_bus_oe_o && !pins_o.ce_n)
    else $error("write strobe low without driven bus");
  AST_WE_RISE_STABLE: assert property ($rose(pins_o.we_n) |->
    $stable(io_bus_o) && $stable(pins_o.cle) && $stable(pins_o.ale))
    else $error("bus changed at write strobe rise");
  AST_CMD_CODES: assert property ($rose(pins_o.we_n) && pins_o.cle |->
    io_bus_o == nand_host_pkg::CMD_READ_SETUP || io_bus_o == nand_host_pkg::CMD_READ_CONFIRM)
    else $error("unexpected command byte");
  AST_READ_RELEASED: assert property (!pins_o.read_strobe_n |->
    !io_bus_oe_o && !pins_o.ce_n && ready_busy_n_i)
    else $error("read strobe with bus driven or device busy");
  AST_READ_PULSE: assert property ($fell(pins_o.read_strobe_n) |->
    !pins_o.read_strobe_n [*3] ##1 pins_o.read_strobe_n)
    else $error("read strobe low time wrong");
  AST_START_CMD: assert property (start_i && ce_i && !busy_o |->
    ##[1:2] (pins_o.cle && !pins_o.ce_n && io_bus_oe_o && io_bus_o == 8'h00))
    else $error("start did not issue read setup");
  AST_DONE_PULSE: assert property (done_o |=> !done_o && pins_o.ce_n)
    else $error("done not a pulse or chip still selected");
  COV_DONE: cover property (done_o);
  COV_TIMEOUT: cover property (timeout_o);
  COV_STALL: cover property (data_valid_o && !data_ready_i);
  COV_REFUSED: cover property (start_i && busy_o);
endmodule // nand_page_reader_sva

bind nand_page_reader nand_page_reader_sva u_sva (.mclk_i, .rstn_i, .ce_i, .start_i,
  .write_enable_i, .protect_i, .busy_o, .done_o, .timeout_o, .data_valid_o, .data_ready_i,
  .pins_o, .io_bus_o, .io_bus_oe_o, .ready_busy_n_i);

// [bench/nand_page_reader_tb.sv]
// self-checking bench for the nand page reader against a device model
`timescale 1ns/10ps
module nand_page_reader_tb;
  localparam int XB = 20;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic start_i = 1'b0;
  logic ce_i = 1'b1;
  logic write_enable_i = 1'b0;
  logic protect_i = 1'b0;
  logic data_ready_i = 1'b0;
  nand_host_pkg::page_addr_t addr_i = '0;
  logic busy_o, done_o, timeout_o, data_valid_o, io_bus_oe_o, rb_low;
  logic [7:0] data_o, io_bus_o, dev_io;
  nand_host_pkg::pin_ctl_t pins_o;
  wire logic [7:0] io_bus_i = io_bus_oe_o ? io_bus_o : dev_io;
  wire logic ready_busy_n_i = !rb_low; // pull-up
  int n_mismatch = 0;
  int comparisons = 0;
  int n_done = 0;
  int n_to = 0;
  always #50 mclk_i = ~mclk_i;
  nand_page_reader #(.READ_LATENCY_CYC(4), .BUSY_TIMEOUT(20), .XFER_BYTES(XB)) dut (
    .mclk_i, .rstn_i, .ce_i, .start_i, .addr_i, .write_enable_i, .protect_i,
    .busy_o, .done_o, .timeout_o, .data_o, .data_valid_o, .data_ready_i, .pins_o,
    .io_bus_o, .io_bus_oe_o, .io_bus_i, .ready_busy_n_i);
  nand_flash_model dev (.pins_i(pins_o), .io_i(io_bus_o), .io_o(dev_io), .rb_low_o(rb_low));
  always @(negedge mclk_i) begin
    if (done_o === 1'b1) n_done++;
    if (timeout_o === 1'b1) n_to++;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one page read; stall holds the consumer off so the fifo fills up
  task automatic run_read(input nand_host_pkg::page_addr_t a, input int stall, input bit mute);
    int n, w, d0, t0;
    logic [11:0] col;
    logic [8:0] e[6];
    n = 0;
    w = 0;
    d0 = n_done;
    t0 = n_to;
    col = {a.col_hi, a.col_lo};
    e = '{9'h000, {1'b1, a.col_lo}, {5'h10, a.col_hi}, {1'b1, a.row_lo}, {1'b1, a.row_hi}, 9'h030};
    dev.log_q.delete();
    dev.no_busy = mute;
    @(negedge mclk_i);
    start_i = 1'b1;
    addr_i = a;
    @(negedge mclk_i);
    start_i = 1'b0;
    addr_i = ~a;
    while (n < XB && w < 3000) begin
      @(negedge mclk_i);
      w++;
      start_i = (w == 5); // a second start while busy must be ignored
      data_ready_i = (w > stall);
      if (w == stall) begin
        chk("strobe held while full", 1, pins_o.read_strobe_n);
        chk("full fifo valid", 1, data_valid_o);
      end
      if (data_valid_o === 1'b1 && data_ready_i) begin
        chk("byte", col[7:0] ^ a.row_lo, data_o);
        col++;
        n++;
      end
    end
    w = 0;
    while (busy_o !== 1'b0 && w < 200) begin
      @(negedge mclk_i);
      w++;
    end
    @(negedge mclk_i);
    chk("bytes", XB, n);
    chk("busy after read", 0, busy_o);
    chk("io released", 0, {io_bus_oe_o, io_bus_o});
    chk("status idle", 8'h60, dev.status);
    chk("done pulses", d0 + 1, n_done);
    chk("timeout pulses", t0 + mute, n_to);
    chk("bus cycles", 6, dev.log_q.size());
    foreach (e[i]) chk("bus cycle", e[i], dev.log_q[i]);
    chk("chip deselected", 1, pins_o.ce_n);
    chk("standby", 1, dev.standby);
  endtask
  // clock enable low freezes the block: no start is taken, pins hold
  task automatic run_freeze();
    @(negedge mclk_i);
    ce_i = 1'b0;
    write_enable_i = 1'b0;
    start_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    chk("frozen wp_n", 1, pins_o.wp_n);
    chk("frozen ce_n", 1, pins_o.ce_n);
    chk("frozen busy", 0, busy_o);
    start_i = 1'b0;
    write_enable_i = 1'b1;
    @(negedge mclk_i);
    ce_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    chk("busy after freeze", 0, busy_o);
    chk("wp_n after freeze", 1, pins_o.wp_n);
  endtask
  initial begin
    repeat (8) @(negedge mclk_i);
    chk("ce_n in reset", 1, pins_o.ce_n);
    chk("wp_n in reset", 0, pins_o.wp_n);
    chk("oe in reset", 0, io_bus_oe_o);
    rstn_i = 1'b1;
    write_enable_i = 1'b1;
    protect_i = 1'b1;
    run_read(28'h83c5aa5, 0, 1'b0);
    chk("wp_n follows", 1, pins_o.wp_n);
    chk("protect follows", 1, pins_o.protect_pin);
    run_freeze();
    run_read(28'h0ff1234, 200, 1'b0);
    protect_i = 1'b0;
    run_read(28'h7ff0080, 0, 1'b1);
    chk("protect low", 0, pins_o.protect_pin);
    test_done();
  end
  initial begin
    #3000000;
    n_mismatch++;
    $display("[FAIL] watchdog expected finish seen hang");
    test_done();
  end
endmodule // nand_page_reader_tb
